// ===== hdl/ssxa_core.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Subtract computes file minus accumulator, two's complement
// - Carry and half carry mean no borrow
// - Borrow subtract also takes the carry flag, uninverted, as carry-in
// - Destination bit picks accumulator or file
// - Nibble exchange swaps halves, flags untouched
// - Immediate XOR into accumulator, zero only
// - File XOR routed by destination, zero only
// - Direction load selects port by 5..7
// - Direction load leaves all flags alone
module ssxa_core #(
   parameter int ADDR_W = 8
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic instr_valid_i,
   input wire ssxa_pkg::ssxa_instr_t instr_i,
   input wire logic [7:0] file_rdata_i,
   output logic file_we_o,
   output logic [6:0] file_waddr_o,
   output logic [7:0] file_wdata_o,
   output logic [7:0] acc_o,
   output logic carry_o,
   output logic half_carry_o,
   output logic zero_o,
   output logic [7:0] port_a_direction_o,
   output logic [7:0] port_b_direction_o,
   output logic [7:0] port_c_direction_o
);
   ssxa_pkg::ssxa_alu_out_t alu;
   logic [7:0] acc_r, acc_nxt;
   logic carry_r, carry_nxt, hc_r, hc_nxt, zero_r, zero_nxt;
   logic [7:0] dir_a_r, dir_a_nxt, dir_b_r, dir_b_nxt, dir_c_r, dir_c_nxt;
   logic fwe_r, fwe_nxt;
   logic [6:0] fwa_r, fwa_nxt;
   logic [7:0] fwd_r, fwd_nxt;
   logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic do_write, exec;
   logic [7:0] wofs, rofs;

   ssxa_alu u_alu (
      .instr_i(instr_i),
      .acc_i(acc_r),
      .file_i(file_rdata_i),
      .carry_i(carry_r),
      .out_o(alu)
   );

   // ==========================================================
   // Bus write channel
   assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
   assign s_axi_wready = ~w_hold_r & ~bvalid_r;
   assign do_write = aw_hold_r & w_hold_r & ~bvalid_r;
   assign wofs = 8'(awaddr_r);

   always_comb begin
      aw_hold_nxt = aw_hold_r;
      awaddr_nxt = awaddr_r;
      w_hold_nxt = w_hold_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold_nxt = 1'b1;
         wdata_nxt = s_axi_wdata[7:0];
         wstrb_nxt = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         // Direction registers are read-only but still answer OKAY
         case (wofs)
            ssxa_pkg::ACC_OFS, ssxa_pkg::STATUS_OFS, ssxa_pkg::DIR_A_OFS,
            ssxa_pkg::DIR_B_OFS, ssxa_pkg::DIR_C_OFS: begin
               bresp_nxt = ssxa_pkg::RESP_OKAY;
            end
            default: begin
               bresp_nxt = ssxa_pkg::RESP_SLVERR;
            end
         endcase
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
   end

   // ==========================================================
   // Bus read channel
   assign s_axi_arready = ~rvalid_r;
   assign rofs = 8'(s_axi_araddr);

   always_comb begin
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = ssxa_pkg::RESP_OKAY;
         rdata_nxt = 32'h0000_0000;
         case (rofs)
            ssxa_pkg::ACC_OFS: begin
               rdata_nxt[7:0] = acc_r;
            end
            ssxa_pkg::STATUS_OFS: begin
               rdata_nxt[ssxa_pkg::CARRY_BIT] = carry_r;
               rdata_nxt[ssxa_pkg::HALF_CARRY_BIT] = hc_r;
               rdata_nxt[ssxa_pkg::ZERO_BIT] = zero_r;
            end
            ssxa_pkg::DIR_A_OFS: begin
               rdata_nxt[7:0] = dir_a_r;
            end
            ssxa_pkg::DIR_B_OFS: begin
               rdata_nxt[7:0] = dir_b_r;
            end
            ssxa_pkg::DIR_C_OFS: begin
               rdata_nxt[7:0] = dir_c_r;
            end
            default: begin
               rresp_nxt = ssxa_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // ==========================================================
   // Execution state
   assign exec = instr_valid_i;

   always_comb begin
      acc_nxt = acc_r;
      carry_nxt = carry_r;
      hc_nxt = hc_r;
      zero_nxt = zero_r;
      dir_a_nxt = dir_a_r;
      dir_b_nxt = dir_b_r;
      dir_c_nxt = dir_c_r;
      fwe_nxt = 1'b0;
      fwa_nxt = fwa_r;
      fwd_nxt = fwd_r;
      // Software write first, so a same-cycle instruction overrides it
      if (do_write && wstrb_r) begin
         if (wofs == ssxa_pkg::ACC_OFS) begin
            acc_nxt = wdata_r;
         end
         if (wofs == ssxa_pkg::STATUS_OFS) begin
            carry_nxt = wdata_r[ssxa_pkg::CARRY_BIT];
            hc_nxt = wdata_r[ssxa_pkg::HALF_CARRY_BIT];
            zero_nxt = wdata_r[ssxa_pkg::ZERO_BIT];
         end
      end
      if (exec) begin
         if (alu.to_acc) begin
            acc_nxt = alu.result;
         end
         if (alu.to_file) begin
            fwe_nxt = 1'b1;
            fwa_nxt = instr_i.addr;
            fwd_nxt = alu.result;
         end
         if (alu.upd_carry) begin
            carry_nxt = alu.carry;
            hc_nxt = alu.half_carry;
         end
         if (alu.upd_zero) begin
            zero_nxt = alu.zero;
         end
         if (alu.to_dir) begin
            // Selectors outside 5..7 are dropped silently
            case (instr_i.addr)
               ssxa_pkg::DIR_SEL_A: dir_a_nxt = alu.result;
               ssxa_pkg::DIR_SEL_B: dir_b_nxt = alu.result;
               ssxa_pkg::DIR_SEL_C: dir_c_nxt = alu.result;
               default: dir_a_nxt = dir_a_r;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         aw_hold_r <= 1'b0;
         awaddr_r <= '0;
         w_hold_r <= 1'b0;
         wdata_r <= 8'h00;
         wstrb_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= ssxa_pkg::RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= ssxa_pkg::RESP_OKAY;
         rdata_r <= 32'h0000_0000;
         acc_r <= ssxa_pkg::ACC_RST;
         carry_r <= ssxa_pkg::FLAG_RST;
         hc_r <= ssxa_pkg::FLAG_RST;
         zero_r <= ssxa_pkg::FLAG_RST;
         dir_a_r <= ssxa_pkg::DIR_RST;
         dir_b_r <= ssxa_pkg::DIR_RST;
         dir_c_r <= ssxa_pkg::DIR_RST;
         fwe_r <= 1'b0;
         fwa_r <= 7'h00;
         fwd_r <= 8'h00;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         awaddr_r <= awaddr_nxt;
         w_hold_r <= w_hold_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         acc_r <= acc_nxt;
         carry_r <= carry_nxt;
         hc_r <= hc_nxt;
         zero_r <= zero_nxt;
         dir_a_r <= dir_a_nxt;
         dir_b_r <= dir_b_nxt;
         dir_c_r <= dir_c_nxt;
         fwe_r <= fwe_nxt;
         fwa_r <= fwa_nxt;
         fwd_r <= fwd_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign file_we_o = fwe_r;
   assign file_waddr_o = fwa_r;
   assign file_wdata_o = fwd_r;
   assign acc_o = acc_r;
   assign carry_o = carry_r;
   assign half_carry_o = hc_r;
   assign zero_o = zero_r;
   assign port_a_direction_o = dir_a_r;
   assign port_b_direction_o = dir_b_r;
   assign port_c_direction_o = dir_c_r;
endmodule // ssxa_core

// ===== hdl/ssxa_pkg.sv
package ssxa_pkg;

   // ==========================================================
   // Operand widths
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int NIB_W = 4;

   // ==========================================================
   // Register map, byte addresses
   localparam logic [7:0] ACC_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] DIR_A_OFS = 8'h08;
   localparam logic [7:0] DIR_B_OFS = 8'h0c;
   localparam logic [7:0] DIR_C_OFS = 8'h10;

   // ==========================================================
   // Status field positions
   localparam int CARRY_BIT = 0;
   localparam int HALF_CARRY_BIT = 1;
   localparam int ZERO_BIT = 2;

   // ==========================================================
   // Reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'hff;
   localparam logic FLAG_RST = 1'b0;

   // ==========================================================
   // Direction selector codes
   localparam logic [6:0] DIR_SEL_A = 7'h05;
   localparam logic [6:0] DIR_SEL_B = 7'h06;
   localparam logic [6:0] DIR_SEL_C = 7'h07;

   // ==========================================================
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Commands
   typedef enum logic [2:0] {
      OP_SUB,
      OP_SUB_BORROW,
      OP_NIBBLE_EXCHANGE,
      OP_XOR_IMMEDIATE,
      OP_XOR_FILE,
      OP_LOAD_DIRECTION
   } ssxa_op_t;

   typedef struct packed {
      ssxa_op_t op;
      logic [6:0] addr;
      logic dest;
      logic [7:0] literal;
   } ssxa_instr_t;

   typedef struct packed {
      logic [7:0] result;
      logic carry;
      logic half_carry;
      logic zero;
      logic upd_carry;
      logic upd_zero;
      logic to_acc;
      logic to_file;
      logic to_dir;
   } ssxa_alu_out_t;

endpackage

// ===== hdl/ssxa_alu.sv
`timescale 1ns/1ns
module ssxa_alu (
   input wire ssxa_pkg::ssxa_instr_t instr_i,
   input wire logic [7:0] acc_i,
   input wire logic [7:0] file_i,
   input wire logic carry_i,
   output ssxa_pkg::ssxa_alu_out_t out_o
);
   logic cin;
   logic [8:0] diff;
   logic [4:0] nib_diff;

   // ==========================================================
   // Subtract as file plus inverted accumulator plus carry-in
   always_comb begin
      cin = (instr_i.op == ssxa_pkg::OP_SUB_BORROW) ? carry_i : 1'b1;
      diff = {1'b0, file_i} + {1'b0, ~acc_i} + {8'h00, cin};
      nib_diff = {1'b0, file_i[3:0]} + {1'b0, ~acc_i[3:0]} + {4'h0, cin};
   end

   always_comb begin
      out_o = '0;
      case (instr_i.op)
         ssxa_pkg::OP_SUB, ssxa_pkg::OP_SUB_BORROW: begin
            out_o.result = diff[7:0];
            out_o.carry = diff[8];
            out_o.half_carry = nib_diff[4];
            out_o.upd_carry = 1'b1;
            out_o.upd_zero = 1'b1;
            out_o.to_acc = ~instr_i.dest;
            out_o.to_file = instr_i.dest;
         end
         ssxa_pkg::OP_NIBBLE_EXCHANGE: begin
            out_o.result = {file_i[3:0], file_i[7:4]};
            out_o.to_acc = ~instr_i.dest;
            out_o.to_file = instr_i.dest;
         end
         ssxa_pkg::OP_XOR_IMMEDIATE: begin
            out_o.result = acc_i ^ instr_i.literal;
            out_o.upd_zero = 1'b1;
            out_o.to_acc = 1'b1;
         end
         ssxa_pkg::OP_XOR_FILE: begin
            out_o.result = acc_i ^ file_i;
            out_o.upd_zero = 1'b1;
            out_o.to_acc = ~instr_i.dest;
            out_o.to_file = instr_i.dest;
         end
         ssxa_pkg::OP_LOAD_DIRECTION: begin
            out_o.result = acc_i;
            out_o.to_dir = 1'b1;
         end
         default: begin
            out_o = '0;
         end
      endcase
      out_o.zero = (out_o.result == 8'h00);
   end
endmodule // ssxa_alu

// ===== tb/ssxa_file_model.sv
`timescale 1ns/1ns
module ssxa_file_model (
   input wire logic clk_i,
   input wire logic [6:0] raddr_i,
   input wire logic we_i,
   input wire logic [6:0] waddr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   // ==========================================
   // File storage, preset so each cell holds its own address
   logic [7:0] mem [128];
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'(i);
      end
   end
   always @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end
   // Bypass so a back-to-back read sees the pending write-back
   assign rdata_o = (we_i && waddr_i == raddr_i) ? wdata_i : mem[raddr_i];
endmodule // ssxa_file_model

// ===== tb/ssxa_core_checker.sv
`timescale 1ns/1ns
module ssxa_core_checker (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic instr_valid_i,
   input wire ssxa_pkg::ssxa_instr_t instr_i,
   input wire logic [7:0] file_rdata_i,
   input wire logic file_we_o,
   input wire logic [6:0] file_waddr_o,
   input wire logic [7:0] file_wdata_o,
   input wire logic [7:0] acc_o,
   input wire logic carry_o,
   input wire logic half_carry_o,
   input wire logic zero_o,
   input wire logic [7:0] port_b_direction_o
);
   // ==========================================
   // Helpers
   logic go;
   logic fop;
   logic [2:0] op;
   logic [2:0] fl;
   logic [8:0] bsum;
   logic [4:0] bhalf;
   assign go = instr_valid_i;
   assign op = instr_i.op;
   assign fl = {zero_o, half_carry_o, carry_o};
   assign fop = op inside {3'h0, 3'h1, 3'h2, 3'h4};
   // Carry-in taken before the edge, so chains see the live flag
   assign bsum = {1'b0, file_rdata_i} + {1'b0, ~acc_o} + {8'h00, carry_o};
   assign bhalf = {1'b0, file_rdata_i[3:0]} + {1'b0, ~acc_o[3:0]} + {4'h0, carry_o};
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   // ==========================================
   // Properties
   AST_SUB_RES: assert property (
      go && op == ssxa_pkg::OP_SUB && !instr_i.dest |=> acc_o == $past(file_rdata_i) - $past(acc_o))
      else $error("subtract result wrong");
   AST_SUB_FLAGS: assert property (
      go && op == ssxa_pkg::OP_SUB |=> carry_o == ($past(acc_o) <= $past(file_rdata_i))
      && half_carry_o == ($past(acc_o[3:0]) <= $past(file_rdata_i[3:0]))
      && zero_o == ($past(file_rdata_i) == $past(acc_o)))
      else $error("subtract flags wrong");
   AST_BORROW: assert property (
      go && op == ssxa_pkg::OP_SUB_BORROW |=> carry_o == $past(bsum[8])
      && half_carry_o == $past(bhalf[4]) && zero_o == ($past(bsum[7:0]) == 8'h00))
      else $error("borrow subtract flags wrong");
   AST_TO_FILE: assert property (
      go && fop && instr_i.dest |=> file_we_o && file_waddr_o == $past(instr_i.addr))
      else $error("file write-back missing");
   AST_TO_ACC: assert property (
      go && (!instr_i.dest || op == ssxa_pkg::OP_XOR_IMMEDIATE) |=> !file_we_o)
      else $error("unexpected file write");
   AST_SWAP: assert property (
      go && op == ssxa_pkg::OP_NIBBLE_EXCHANGE |=> $stable(fl)
      && ($past(instr_i.dest) ? file_wdata_o : acc_o)
      == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])})
      else $error("nibble exchange wrong");
   AST_XOR_IMM: assert property (
      go && op == ssxa_pkg::OP_XOR_IMMEDIATE |=> acc_o == ($past(acc_o) ^ $past(instr_i.literal))
      && zero_o == (acc_o == 8'h00) && $stable(fl[1:0]))
      else $error("immediate xor wrong");
   AST_XOR_FILE: assert property (
      go && op == ssxa_pkg::OP_XOR_FILE && instr_i.dest
      |=> file_wdata_o == ($past(acc_o) ^ $past(file_rdata_i))
      && zero_o == (file_wdata_o == 8'h00) && $stable(fl[1:0]))
      else $error("file xor wrong");
   AST_DIR_B: assert property (
      go && op == ssxa_pkg::OP_LOAD_DIRECTION && instr_i.addr == ssxa_pkg::DIR_SEL_B
      |=> port_b_direction_o == $past(acc_o) && $stable(fl))
      else $error("direction load wrong");
endmodule // ssxa_core_checker
bind ssxa_core ssxa_core_checker u_chk (.ref_clk_i, .resetn_i, .instr_valid_i, .instr_i,
   .file_rdata_i, .file_we_o, .file_waddr_o, .file_wdata_o, .acc_o, .carry_o,
   .half_carry_o, .zero_o, .port_b_direction_o);

// ===== tb/subtract_swap_xor_alu_test.sv
`timescale 1ns/1ns
module subtract_swap_xor_alu_test;
   typedef struct packed {
      logic [2:0] op; logic [6:0] a; logic d; logic [7:0] k; logic [7:0] w;
      logic [2:0] st; logic [7:0] r; logic [2:0] fl; logic we;
   } ssxa_row_t;
   logic ref_clk_i, resetn_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, instr_valid_i, file_we_o, carry_o, half_carry_o, zero_o;
   logic [7:0] s_axi_awaddr, s_axi_araddr, file_rdata_i, file_wdata_o, acc_o;
   logic [7:0] port_a_direction_o, port_b_direction_o, port_c_direction_o;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [6:0] file_waddr_o;
   ssxa_pkg::ssxa_instr_t instr_i;
   ssxa_row_t rw;
   int fails, check_count, cyc;
   // {z,dc,c} in st and fl; file cell n holds n
   ssxa_row_t rows [16] = '{
      '{3'h0,7'h03,1'h0,8'h00,8'h01,3'h0,8'h02,3'h3,1'h0},
      '{3'h0,7'h10,1'h1,8'h00,8'h01,3'h0,8'h0f,3'h1,1'h1},
      '{3'h0,7'h05,1'h0,8'h00,8'h09,3'h0,8'hfc,3'h0,1'h0},
      '{3'h0,7'h07,1'h0,8'h00,8'h07,3'h0,8'h00,3'h7,1'h0},
      '{3'h1,7'h07,1'h0,8'h00,8'h07,3'h0,8'hff,3'h0,1'h0},
      '{3'h1,7'h14,1'h1,8'h00,8'h04,3'h1,8'h10,3'h3,1'h1},
      '{3'h2,7'h5a,1'h0,8'h00,8'h33,3'h5,8'ha5,3'h5,1'h0},
      '{3'h2,7'h64,1'h1,8'h00,8'h00,3'h2,8'h46,3'h2,1'h1},
      '{3'h3,7'h00,1'h1,8'h3c,8'h3c,3'h3,8'h00,3'h7,1'h0},
      '{3'h3,7'h00,1'h0,8'hf0,8'h0f,3'h4,8'hff,3'h0,1'h0},
      '{3'h4,7'h55,1'h1,8'h00,8'h55,3'h3,8'h00,3'h7,1'h1},
      '{3'h4,7'h0a,1'h0,8'h00,8'h03,3'h4,8'h09,3'h0,1'h0},
      '{3'h5,7'h05,1'h1,8'h00,8'h11,3'h5,8'h11,3'h5,1'h0},
      '{3'h5,7'h06,1'h0,8'h00,8'h22,3'h2,8'h22,3'h2,1'h0},
      '{3'h5,7'h07,1'h0,8'h00,8'h33,3'h0,8'h33,3'h0,1'h0},
      '{3'h5,7'h04,1'h0,8'h00,8'h44,3'h7,8'h44,3'h7,1'h0}};
   ssxa_core i_dut (.ref_clk_i, .resetn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instr_valid_i,
      .instr_i, .file_rdata_i, .file_we_o, .file_waddr_o, .file_wdata_o, .acc_o,
      .carry_o, .half_carry_o, .zero_o, .port_a_direction_o, .port_b_direction_o,
      .port_c_direction_o);
   ssxa_file_model u_mem (.clk_i(ref_clk_i), .raddr_i(instr_i.addr), .we_i(file_we_o),
      .waddr_i(file_waddr_o), .wdata_i(file_wdata_o), .rdata_o(file_rdata_i));
   // ==========================================
   // Helpers
   // Wide enough for the packed reset snapshots
   task automatic chk(string n, logic [63:0] e, logic [63:0] s);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Leading edge wait keeps back-to-back calls from double driving
   task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er);
      @(posedge ref_clk_i);
      s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e, logic [1:0] er);
      @(posedge ref_clk_i);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask
   task automatic ex(ssxa_pkg::ssxa_instr_t i);
      instr_i <= i; instr_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      instr_valid_i <= 1'b0;
   endtask
   // ==========================================
   // Clock, timeout, sequence
   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      {resetn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, instr_valid_i, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf; instr_i = '0;
      repeat (8) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      #1 chk("reset", {ssxa_pkg::ACC_RST, {3{ssxa_pkg::FLAG_RST}}, {3{ssxa_pkg::DIR_RST}}},
         {acc_o, carry_o, half_carry_o, zero_o,
         port_a_direction_o, port_b_direction_o, port_c_direction_o});
      foreach (rows[n]) begin
         rw = rows[n];
         wr(ssxa_pkg::ACC_OFS, rw.w, ssxa_pkg::RESP_OKAY);
         wr(ssxa_pkg::STATUS_OFS, {5'h0, rw.st}, ssxa_pkg::RESP_OKAY);
         ex('{ssxa_pkg::ssxa_op_t'(rw.op), rw.a, rw.d, rw.k});
         #1 chk("acc", rw.we ? rw.w : rw.r, acc_o);
         chk("flags", rw.fl, {zero_o, half_carry_o, carry_o});
         chk("we", rw.we, file_we_o);
         if (rw.we) chk("wb", {rw.a, rw.r}, {file_waddr_o, file_wdata_o});
      end
      chk("dirs", 24'h112233, {port_a_direction_o, port_b_direction_o,
         port_c_direction_o});
      rd(ssxa_pkg::STATUS_OFS, 8'h07, ssxa_pkg::RESP_OKAY);
      wr(8'h20, 8'h5a, ssxa_pkg::RESP_SLVERR);
      rd(8'h20, 8'h00, ssxa_pkg::RESP_SLVERR);
      wr(ssxa_pkg::DIR_A_OFS, 8'h00, ssxa_pkg::RESP_OKAY);
      rd(ssxa_pkg::DIR_A_OFS, 8'h11, ssxa_pkg::RESP_OKAY);
      // Back to back borrow chain: second step must use the fresh carry
      wr(ssxa_pkg::ACC_OFS, 8'h01, ssxa_pkg::RESP_OKAY);
      wr(ssxa_pkg::STATUS_OFS, 8'h00, ssxa_pkg::RESP_OKAY);
      instr_valid_i <= 1'b1;
      instr_i <= '{ssxa_pkg::OP_SUB_BORROW, 7'h02, 1'b0, 8'h00};
      @(posedge ref_clk_i);
      instr_i <= '{ssxa_pkg::OP_SUB_BORROW, 7'h03, 1'b0, 8'h00};
      @(posedge ref_clk_i);
      instr_valid_i <= 1'b0;
      #1 chk("chain", 11'h01b, {acc_o, zero_o, half_carry_o, carry_o});
      @(posedge ref_clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      // Carry and half carry were left set by the chain, so this proves they clear
      #1 chk("rerun", {ssxa_pkg::ACC_RST, {3{ssxa_pkg::FLAG_RST}}, {3{ssxa_pkg::DIR_RST}}},
         {acc_o, carry_o, half_carry_o, zero_o,
         port_a_direction_o, port_b_direction_o, port_c_direction_o});
      final_report();
   end
endmodule // subtract_swap_xor_alu_test
